// [core/ipi_pkg.sv]
// constants and carrier types for the plug-and-play isolation logic
// Behaviour
// - vendor unlock sequence is 32 fixed writes DA, 6D ... 50 to the address port.
// - any mismatch restarts detection; ports open only after all 32 match.
// - vendor sequence works in every mode, standard one only in PnP mode.
// - 72-bit identifier: 32 vendor, 32 serial, 8 checksum, vendor byte 0 first.
// - bits within each byte go out bit 0 first up to bit 7.
// - an isolation pass is 72 read pairs on the read-data port.
// - first read: bit 1 drives 55, bit 0 floats and senses 01 on bits 1:0.
// - second read: drivers send AA, floating cards sense 10 on bits 1:0.
// - floating card sensing both patterns drops from this pass, not later ones.
// - answers drive all eight bits, sensing compares only the low two.
// - surviving card advances one identifier bit after each pair.
// - nonzero select number skips isolation; commands need a select number.
// - checksum register loads 6A on every wake command.
// - each of the first 64 pair ends shifts right, new bit 7 = bit1 ^ bit0 ^ serial bit.
// - after 64 pairs the register holds the checksum, sent as last 8 bits.
// - never drive the wait signal during isolation.
// - reset drive returns to wait-for-key and clears the select number.
// - wait-for-key command returns there; number clears change no state.
// - after reset the card reloads configuration; host stays off for 2 ms.
// - wait-for-key ignores port accesses until unlock, then goes to sleep.
// - wake 00 in sleep sends zero-number cards to isolation, pointer to start.
// - losers sleep, winner gets number and config; wake 0 sends it to sleep.
`default_nettype none
package ipi_pkg;

	localparam int KEY_LEN = 32;
	localparam int ID_BITS = 72;
	localparam int SER_BITS = 64;

	localparam logic [0:31][7:0] VEND_KEY = {
		8'hda, 8'h6d, 8'h36, 8'h1b, 8'h8d, 8'h46, 8'h23, 8'h91,
		8'h48, 8'ha4, 8'hd2, 8'h69, 8'h34, 8'h9a, 8'h4d, 8'h26,
		8'h13, 8'h89, 8'h44, 8'ha2, 8'h51, 8'h28, 8'h94, 8'hca,
		8'h65, 8'h32, 8'h19, 8'h0c, 8'h86, 8'h43, 8'ha1, 8'h50};
	localparam logic [0:31][7:0] STD_KEY = {
		8'h6a, 8'hb5, 8'hda, 8'hed, 8'hf6, 8'hfb, 8'h7d, 8'hbe,
		8'hdf, 8'h6f, 8'h37, 8'h1b, 8'h0d, 8'h86, 8'hc3, 8'h61,
		8'hb0, 8'h58, 8'h2c, 8'h16, 8'h8b, 8'h45, 8'ha2, 8'hd1,
		8'he8, 8'h74, 8'h3a, 8'h9d, 8'hce, 8'he7, 8'h73, 8'h39};

	localparam logic [7:0] ANS_FIRST = 8'h55;
	localparam logic [7:0] ANS_SECOND = 8'haa;
	localparam logic [1:0] SENSE_FIRST = 2'h1;
	localparam logic [1:0] SENSE_SECOND = 2'h2;
	localparam logic [7:0] LFSR_SEED = 8'h6a;
	localparam logic [7:0] WAKE_ALL = 8'h00;
	localparam logic [7:0] CSN_NONE = 8'h00;

	typedef enum logic [1:0] {
		IPI_WFK   = 2'h0,
		IPI_SLEEP = 2'h1,
		IPI_ISO   = 2'h3,
		IPI_CFG   = 2'h2
	} ipi_state_t;

	// one-cycle command strobes decoded by the port logic, with write data
	typedef struct packed {
		logic       addr_wr;
		logic       wake;
		logic       csn_wr;
		logic       wait_key;
		logic       csn_clr;
		logic       vend_csn_clr;
		logic       cfg_reset;
		logic [7:0] data;
	} ipi_cmd_t;

endpackage
`default_nettype wire

// [core/ipi_isolation.sv]
// card-side isolation logic: unlock detect, card states, serial shifting, checksum
`timescale 1ns/1ns
`default_nettype none
module ipi_isolation
(
	input  wire logic            CLK,
	input  wire logic            RST_N,
	input  wire logic            RSTDRV,
	input  wire logic            PNP_MODE,
	input  wire ipi_pkg::ipi_cmd_t CMD,
	input  wire logic            ISO_RD,
	input  wire logic            ISO_RD_END,
	input  wire logic [1:0]      SD_IN,
	input  wire logic [63:0]     SERIAL_ID,
	input  wire logic            WAIT_REQ,
	output logic [7:0]           SD_OUT,
	output logic                 SD_OE,
	output logic                 IOCHRDY_OE,
	output logic [1:0]           STATE,
	output logic [7:0]           CSN,
	output logic                 CMD_EN,
	output logic                 CFG_LOAD,
	output logic                 RES_PTR_START
);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic       rst_m_q;
	logic       rst_s_q;
	logic       rst_d_q;   // edge stage, keeps the first flop private to the synchroniser
	logic [1:0] sd_m_q;
	logic [1:0] sd_s_q;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
			rst_d_q <= 1'b0;
			sd_m_q  <= 2'h0;
			sd_s_q  <= 2'h0;
		end
		else
		begin
			rst_m_q <= RSTDRV;
			rst_s_q <= rst_m_q;
			rst_d_q <= rst_s_q;
			sd_m_q  <= SD_IN;
			sd_s_q  <= sd_m_q;
		end
	end

	// ****************************************
	// unlock sequence detectors
	// ****************************************
	ipi_pkg::ipi_state_t state_q;
	logic [1:0]          key_hit;
	logic [1:0]          key_ok;

	assign key_ok[0] = 1'b1;        // vendor sequence in every mode
	assign key_ok[1] = PNP_MODE;    // standard sequence only in PnP mode

	genvar k;
	generate
		for (k = 0; k < 2; k++)
		begin : g_key
			logic [4:0] idx_q;
			logic [7:0] want;
			logic [7:0] first;

			assign want  = (k == 0) ? ipi_pkg::VEND_KEY[idx_q] : ipi_pkg::STD_KEY[idx_q];
			assign first = (k == 0) ? ipi_pkg::VEND_KEY[0] : ipi_pkg::STD_KEY[0];
			assign key_hit[k] = CMD.addr_wr && key_ok[k] && CMD.data == want && idx_q == 5'h1f;

			always_ff @(posedge CLK or negedge RST_N)
			begin
				if (!RST_N)
					idx_q <= 5'h00;
				else if (rst_s_q || !key_ok[k])
					idx_q <= 5'h00;
				else if (CMD.addr_wr)
				begin
					// a mismatching byte may itself start a new sequence
					if (CMD.data == want)
						idx_q <= idx_q + 5'h01;
					else if (CMD.data == first)
						idx_q <= 5'h01;
					else
						idx_q <= 5'h00;
				end
			end
		end
	endgenerate

	// ****************************************
	// card state and select number
	// ****************************************
	logic       act;
	logic       cur_bit;
	logic       phase_q;
	logic [6:0] bit_q;
	logic       sense_q;
	logic       pair_end;
	logic       lose;

	// commands are ignored while waiting for the unlock
	assign act      = state_q != ipi_pkg::IPI_WFK;
	assign pair_end = state_q == ipi_pkg::IPI_ISO && ISO_RD_END && phase_q;
	assign lose     = pair_end && !cur_bit && sense_q && sd_s_q == ipi_pkg::SENSE_SECOND;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			state_q <= ipi_pkg::IPI_WFK;
		else if (rst_s_q)
			state_q <= ipi_pkg::IPI_WFK;
		else if (CMD.wait_key && act)
			state_q <= ipi_pkg::IPI_WFK;
		else
		begin
			unique case (state_q)
				ipi_pkg::IPI_WFK:
					if (|key_hit)
						state_q <= ipi_pkg::IPI_SLEEP;
				ipi_pkg::IPI_SLEEP:
					if (CMD.wake && CMD.data == ipi_pkg::WAKE_ALL && CSN == ipi_pkg::CSN_NONE)
						state_q <= ipi_pkg::IPI_ISO;
					else if (CMD.wake && CMD.data == CSN && CSN != ipi_pkg::CSN_NONE)
						state_q <= ipi_pkg::IPI_CFG;
				ipi_pkg::IPI_ISO:
					if (lose)
						state_q <= ipi_pkg::IPI_SLEEP;
					else if (CMD.csn_wr)
						state_q <= ipi_pkg::IPI_CFG;
					else if (CMD.wake && CMD.data != CSN)
						state_q <= ipi_pkg::IPI_SLEEP;
				ipi_pkg::IPI_CFG:
					if (CMD.wake && CMD.data != CSN)
						state_q <= ipi_pkg::IPI_SLEEP;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			CSN <= ipi_pkg::CSN_NONE;
		else if (rst_s_q)
			CSN <= ipi_pkg::CSN_NONE;
		else if (act && (CMD.csn_clr || CMD.vend_csn_clr))
			CSN <= ipi_pkg::CSN_NONE;
		else if (CMD.csn_wr && (state_q == ipi_pkg::IPI_ISO || state_q == ipi_pkg::IPI_CFG))
			CSN <= CMD.data;
	end

	// configuration reload after reset drive or configuration reset
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			CFG_LOAD <= 1'b0;
		else
			CFG_LOAD <= (rst_d_q && !rst_s_q) || (act && CMD.cfg_reset);
	end

	// ****************************************
	// serial identifier and checksum
	// ****************************************
	logic [7:0] lfsr_q;

	// first 64 bits from storage, last 8 from the live checksum register
	assign cur_bit = (bit_q < 7'(ipi_pkg::SER_BITS)) ? SERIAL_ID[bit_q[5:0]] : lfsr_q[bit_q[2:0]];

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			bit_q   <= 7'h00;
			phase_q <= 1'b0;
			sense_q <= 1'b0;
		end
		else if (CMD.wake && act)
		begin
			bit_q   <= 7'h00;
			phase_q <= 1'b0;
			sense_q <= 1'b0;
		end
		else if (state_q == ipi_pkg::IPI_ISO && ISO_RD_END)
		begin
			phase_q <= !phase_q;
			if (!phase_q)
				sense_q <= !cur_bit && sd_s_q == ipi_pkg::SENSE_FIRST;
			else if (!lose && bit_q < 7'(ipi_pkg::ID_BITS))
				bit_q <= bit_q + 7'h01;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			lfsr_q <= ipi_pkg::LFSR_SEED;
		else if (CMD.wake && act)
			lfsr_q <= ipi_pkg::LFSR_SEED;
		else if (pair_end && !lose && bit_q < 7'(ipi_pkg::SER_BITS))
			lfsr_q <= {lfsr_q[1] ^ lfsr_q[0] ^ cur_bit, lfsr_q[7:1]};
	end

	// pointer now rests on the first resource byte
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			RES_PTR_START <= 1'b0;
		else
			RES_PTR_START <= pair_end && !lose && bit_q == 7'(ipi_pkg::ID_BITS - 1);
	end

	// ****************************************
	// bus answers
	// ****************************************
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SD_OE  <= 1'b0;
			SD_OUT <= 8'h00;
		end
		else if (ISO_RD_END || state_q != ipi_pkg::IPI_ISO)
			SD_OE <= 1'b0;
		else if (ISO_RD && cur_bit)
		begin
			SD_OE  <= 1'b1;
			SD_OUT <= phase_q ? ipi_pkg::ANS_SECOND : ipi_pkg::ANS_FIRST;
		end
	end

	// wait requests are blocked outright during isolation
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			IOCHRDY_OE <= 1'b0;
		else
			IOCHRDY_OE <= WAIT_REQ && state_q != ipi_pkg::IPI_ISO && !(act && CMD.wake);
	end

	assign STATE  = state_q;
	assign CMD_EN = state_q == ipi_pkg::IPI_CFG && CSN != ipi_pkg::CSN_NONE;

	// ****************************************
	// checks
	// ****************************************
	no_wait_iso_a: assert property (@(posedge CLK) disable iff (!RST_N)
		state_q == ipi_pkg::IPI_ISO |-> !IOCHRDY_OE)
		else $error("wait driven during isolation");

	first_ans_a: assert property (@(posedge CLK) disable iff (!RST_N)
		state_q == ipi_pkg::IPI_ISO && ISO_RD && !ISO_RD_END && cur_bit && !phase_q && !rst_s_q && !CMD.wake
		|=> SD_OE && SD_OUT == 8'h55)
		else $error("first answer not 55");

	second_ans_a: assert property (@(posedge CLK) disable iff (!RST_N)
		state_q == ipi_pkg::IPI_ISO && ISO_RD && !ISO_RD_END && cur_bit && phase_q && !rst_s_q && !CMD.wake
		|=> SD_OE && SD_OUT == 8'haa)
		else $error("second answer not aa");

	zero_float_a: assert property (@(posedge CLK) disable iff (!RST_N)
		ISO_RD && !cur_bit && !SD_OE |=> !SD_OE)
		else $error("zero bit drove the bus");

	loser_sleep_a: assert property (@(posedge CLK) disable iff (!RST_N)
		lose && !rst_s_q && !CMD.wait_key && !CMD.wake |=> state_q == ipi_pkg::IPI_SLEEP && $stable(bit_q))
		else $error("loser stayed in isolation");

	wake_seed_a: assert property (@(posedge CLK) disable iff (!RST_N)
		CMD.wake && act |=> lfsr_q == 8'h6a && bit_q == 7'h00)
		else $error("wake did not seed checksum");

	rstdrv_wfk_a: assert property (@(posedge CLK) disable iff (!RST_N)
		rst_s_q |=> state_q == ipi_pkg::IPI_WFK && CSN == 8'h00)
		else $error("reset drive ignored");

	csn_clr_keep_a: assert property (@(posedge CLK) disable iff (!RST_N)
		act && CMD.csn_clr && !CMD.wake && !CMD.wait_key && !CMD.csn_wr && !rst_s_q && !lose
		|=> CSN == 8'h00 && state_q == $past(state_q))
		else $error("number clear changed state");

	wfk_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N)
		state_q == ipi_pkg::IPI_WFK && !(|key_hit) |=> state_q == ipi_pkg::IPI_WFK)
		else $error("left wait-for-key without unlock");

	bit_advance_a: assert property (@(posedge CLK) disable iff (!RST_N)
		pair_end && !lose && bit_q < 7'd72 && !CMD.wake && !rst_s_q |=> bit_q == $past(bit_q) + 7'h01)
		else $error("identifier did not advance");

	numbered_no_iso_a: assert property (@(posedge CLK) disable iff (!RST_N)
		state_q == ipi_pkg::IPI_SLEEP && CSN != ipi_pkg::CSN_NONE |=> state_q != ipi_pkg::IPI_ISO)
		else $error("numbered card entered isolation");

	key_restart_a: assert property (@(posedge CLK) disable iff (!RST_N)
		CMD.addr_wr && !rst_s_q && CMD.data != g_key[0].want && CMD.data != g_key[0].first |=> g_key[0].idx_q == 5'h00)
		else $error("unlock detector did not restart");

endmodule
`default_nettype wire

// [tb/ipi_host_model.sv]
// bus partner: a rival card and the pulled-up isa data lines
`timescale 1ns/1ns
`default_nettype none
module ipi_host_model
(
	input  wire logic       dut_oe,
	input  wire logic [7:0] dut_out,
	input  wire logic       rival_on,
	input  wire logic       second,
	output logic [1:0]      sd_bits
);
	// *****
	// bus resolution
	// *****
	logic [7:0] bus;

	always_comb
	begin
		if (dut_oe)
			bus = dut_out;
		else if (rival_on)
			bus = second ? 8'haa : 8'h55;
		else
			bus = 8'hff;
		sd_bits = bus[1:0];
	end
endmodule
`default_nettype wire

// [tb/isa_pnp_isolation_logic_test.sv]
// self-checking bench for the isolation logic
`timescale 1ns/1ns
`default_nettype none
module isa_pnp_isolation_logic_test;
	logic              CLK, RST_N, RSTDRV, PNP_MODE, ISO_RD, ISO_RD_END, WAIT_REQ;
	logic              SD_OE, IOCHRDY_OE, CMD_EN, CFG_LOAD, RES_PTR_START, rival_on, second;
	ipi_pkg::ipi_cmd_t CMD;
	logic [1:0]        SD_IN, STATE;
	logic [63:0]       SERIAL_ID;
	logic [7:0]        SD_OUT, CSN, exp_state, exp_csn, l, n;
	logic              seen;
	logic [71:0]       got_id;
	int                failures, checks, ptr_cnt, cfg_cnt, i;
	int                bits[$];

	ipi_isolation u_dut (.CLK(CLK), .RST_N(RST_N), .RSTDRV(RSTDRV), .PNP_MODE(PNP_MODE), .CMD(CMD),
		.ISO_RD(ISO_RD), .ISO_RD_END(ISO_RD_END), .SD_IN(SD_IN), .SERIAL_ID(SERIAL_ID),
		.WAIT_REQ(WAIT_REQ), .SD_OUT(SD_OUT), .SD_OE(SD_OE), .IOCHRDY_OE(IOCHRDY_OE), .STATE(STATE),
		.CSN(CSN), .CMD_EN(CMD_EN), .CFG_LOAD(CFG_LOAD), .RES_PTR_START(RES_PTR_START));
	ipi_host_model u_host (.dut_oe(SD_OE), .dut_out(SD_OUT), .rival_on(rival_on), .second(second),
		.sd_bits(SD_IN));

	initial
	begin
		CLK = 0;
		forever #50 CLK = ~CLK;
	end

	always @(negedge CLK)
	begin
		ptr_cnt += RES_PTR_START;
		cfg_cnt += CFG_LOAD;
	end

	// *****
	// tasks
	// *****
	task wrap_up;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task regs;
		@(negedge CLK);
		chk(8'(STATE), exp_state);
		chk(CSN, exp_csn);
		chk(8'(CMD_EN), 8'(exp_state == 2 && exp_csn != 0));
	endtask

	// k picks the command flag, 0 = address-port write
	task send(input int k, input logic [7:0] d);
		@(negedge CLK);
		CMD = ipi_pkg::ipi_cmd_t'({7'h40 >> k, d});
		@(negedge CLK);
		CMD = '0;
		if (exp_state != 0)
			case (k)
				1: if (exp_state == 1 && d == exp_csn) exp_state = d == 0 ? 8'h3 : 8'h2;
					else if (exp_state != 1 && d != exp_csn) exp_state = 1;
				2: if (exp_state > 1) {exp_state, exp_csn} = {8'h2, d};
				3: exp_state = 0;
				4, 5: exp_csn = 0;
				default: ;
			endcase
	endtask

	task key(input logic std, input int cnt);
		for (int j = 0; j < cnt; j++)
			send(0, std ? ipi_pkg::STD_KEY[j] : ipi_pkg::VEND_KEY[j]);
	endtask

	// the device does not time the gap, so a short gap stands in for the host's delay
	task rd(input logic sec, input int b);
		@(negedge CLK);
		second = sec;
		ISO_RD = 1;
		@(negedge CLK);
		ISO_RD = 0;
		@(negedge CLK);
		chk(8'(SD_OE), 8'(b));
		seen = SD_OE;
		if (b)
			chk(SD_OUT, sec ? 8'haa : 8'h55);
		chk(8'(IOCHRDY_OE), 8'h0);
		repeat (2) @(negedge CLK);
		ISO_RD_END = 1;
		@(negedge CLK);
		ISO_RD_END = 0;
	endtask

	task pass(input logic riv);
		ptr_cnt = 0;
		rival_on = riv;
		for (i = 0; i < 72 && exp_state == 3; i++)
		begin
			rd(0, bits[i]);
			rd(1, bits[i]);
			got_id[i] = seen;
			if (riv && !bits[i])
				exp_state = 1;
			regs();
		end
		rival_on = 0;
		// the host's own checksum over what it read must match the last 8 bits it read
		if (!riv)
		begin
			l = 8'h6a;
			for (int j = 0; j < 64; j++)
				l = {l[1] ^ l[0] ^ got_id[j], l[7:1]};
			chk(got_id[71:64], l);
		end
	endtask

	initial
	begin
		repeat (100000) @(posedge CLK);
		failures++;
		wrap_up();
	end

	// *****
	// stimulus
	// *****
	initial
	begin
		{RST_N, RSTDRV, PNP_MODE, ISO_RD, ISO_RD_END, rival_on, second} = '0;
		CMD = '0;
		WAIT_REQ = 1;
		{exp_state, exp_csn, failures, checks, ptr_cnt, cfg_cnt} = '0;
		void'($urandom(70305));
		SERIAL_ID = {$urandom, $urandom};
		n = 8'($urandom_range(255, 1));
		l = 8'h6a;
		for (i = 0; i < 64; i++)
		begin
			bits.push_back(SERIAL_ID[i]);
			l = {l[1] ^ l[0] ^ SERIAL_ID[i], l[7:1]};
		end
		for (i = 0; i < 8; i++)
			bits.push_back(l[i]);
		repeat (8) @(negedge CLK);
		RST_N = 1;
		regs();
		chk(8'(IOCHRDY_OE), 8'h1);
		send(1, 8'h00);
		regs();
		$display("test 1 done");
		key(1, 32);
		regs();
		key(0, 31);
		send(0, 8'h00);
		send(0, ipi_pkg::VEND_KEY[31]);
		regs();
		PNP_MODE = 1;
		key(1, 32);
		exp_state = 1;
		regs();
		send(3, 8'h00);
		regs();
		key(0, 32);
		exp_state = 1;
		regs();
		$display("test 2 done");
		send(1, 8'h00);
		regs();
		pass(0);
		chk(8'(ptr_cnt), 8'h1);
		send(2, n);
		regs();
		send(5, 8'h00);
		regs();
		send(2, n);
		$display("test 3 done");
		send(1, 8'h00);
		regs();
		send(1, 8'h00);
		regs();
		send(4, 8'h00);
		regs();
		send(1, 8'h00);
		pass(1);
		chk(8'(ptr_cnt), 8'h0);
		send(1, 8'h00);
		regs();
		send(2, n);
		cfg_cnt = 0;
		send(6, 8'h00);
		@(negedge CLK);
		chk(8'(cfg_cnt), 8'h1);
		$display("test 4 done");
		cfg_cnt = 0;
		RSTDRV = 1;
		repeat (4) @(negedge CLK);
		{exp_state, exp_csn} = '0;
		regs();
		RSTDRV = 0;
		repeat (6) @(negedge CLK);
		chk(8'(cfg_cnt), 8'h1);
		$display("test 5 done");
		wrap_up();
	end
endmodule
`default_nettype wire
